// *** core/wpc_wake_power_ctrl.sv ***
// wake, low power state and phy basic control logic
// Contract
// (RULE_01) enabled wake sets cause, pending, wake output
// (RULE_02) clearing request enable releases wake request
// (RULE_03) host restores power level and bus config
// (RULE_04) host flushes wake patterns via transmit reset
// (RULE_05) host reads cause, restores state and lists
// (RULE_06) wake frames drained by receive dma later
// (RULE_07) base write enters unpowered; ready excludes it
// (RULE_08) unpowered: phy off, only bus clock runs
// (RULE_09) ready state keeps phy powered and usable
// (RULE_10) fixed setup mode stays always ready
// (RULE_11) nonzero base field also means unpowered
// (RULE_12) remote wake mode forces unpowered low
// (RULE_13) deep sleep without request enters power down
// (RULE_14) phy registers reached only over management port
// (RULE_15) control register 16 bits, address 0, 0x3100
// (RULE_16) bit 15 self clearing reset, blocks writes
// (RULE_17) bit 14 loopback, collision only with test
// (RULE_18) bit 13 speed, bit 8 duplex
// (RULE_19) bit 12 autoneg enable, bit 9 restart
// (RULE_20) bit 11 power down ignores data
// (RULE_21) bit 10 isolate ignores mac data
// (RULE_22) bit 7 collision test within bit limits
// (RULE_23) wake events only in sleep levels
// (RULE_24) reserved bits 6..0 read zero
`timescale 1ns/1ps
`default_nettype none

module wpc_wake_power_ctrl (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire wpc_pkg::wpc_mgmt_req_t mgmtReq,
	output logic [15:0] mgmtRdData,
	output logic mgmtRdValid,
	input wire wpc_pkg::wpc_pwr_ctrl_t pwrCtrl,
	input wire logic [wpc_pkg::WAKE_CAUSES-1:0] wakeEventIn,
	input wire logic ioBaseWrite,
	input wire logic memBaseWrite,
	input wire logic ioBaseNonZero,
	input wire logic memBaseNonZero,
	input wire logic fixedSetupMode,
	input wire logic remoteWakeMode,
	input wire logic receiveEnabled,
	input wire logic txDataActive,
	input wire logic mediumCollision,
	output logic [wpc_pkg::WAKE_CAUSES-1:0] wakeCause,
	output logic wakePending,
	output logic wakeOut,
	output logic wakeRequest_n,
	output wpc_pkg::wpc_pwr_t sleep_level_field,
	output wpc_pkg::wpc_clk_pwr_t clkPwr,
	output wpc_pkg::wpc_phy_mode_t phyMode,
	output logic rxWakeDrain
);
	import wpc_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		wpc_pwr_t pwr;
		logic [WAKE_CAUSES-1:0] cause;
		logic pending;
		logic wakeReqN;
		logic [15:0] ctrl;
		logic [7:0] rstCnt;
		logic [15:0] rdData;
		logic rdValid;
		wpc_clk_pwr_t clk;
		wpc_phy_mode_t mode;
		logic rxDrain;
	} wpc_state_t;

	wpc_state_t state_r;
	wpc_state_t state_nxt;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic isSleeping(input logic [1:0] lvl);
		isSleeping = (lvl != SLEEP_FULL_POWER);
	endfunction : isSleeping

	function automatic logic isCtrlAddr(input logic [4:0] a);
		isCtrlAddr = (a == CTRL_ADDR);
	endfunction : isCtrlAddr

	logic [WAKE_CAUSES-1:0] wakeHit;
	logic resetBusy;
	logic ctrlWrite;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		state_nxt.rdValid = 1'b0;
		state_nxt.mode.autoNegRestart = 1'b0;

		// events are dropped at full power
		wakeHit = wakeEventIn & pwrCtrl.wakeEnable
			& {WAKE_CAUSES{isSleeping(pwrCtrl.sleepLevel)}}; // RULE_23

		// set wins over a clear in the same cycle
		state_nxt.cause = (state_r.cause & ~pwrCtrl.wakeCauseClear)
			| wakeHit; // RULE_01
		state_nxt.pending = (state_r.pending & ~pwrCtrl.wakePendingClear)
			| (|wakeHit); // RULE_01
		state_nxt.wakeReqN = ~(state_nxt.pending
			& pwrCtrl.wakeRequestEnable); // RULE_02

		// phy soft reset countdown
		resetBusy = (state_r.rstCnt != 8'h00);
		if (resetBusy) begin
			state_nxt.rstCnt = state_r.rstCnt - 8'h01;
			if (state_r.rstCnt == 8'h01) begin
				state_nxt.ctrl[BIT_RESET] = 1'b0; // RULE_16
			end
		end

		// management port is the only path to the phy register
		ctrlWrite = mgmtReq.wrEn & isCtrlAddr(mgmtReq.addr)
			& ~resetBusy; // RULE_14 RULE_16
		if (ctrlWrite) begin
			if (mgmtReq.wrData[BIT_RESET]) begin
				state_nxt.ctrl = CTRL_RESET; // RULE_15
				state_nxt.ctrl[BIT_RESET] = 1'b1; // RULE_16
				state_nxt.rstCnt = PHY_RESET_CYCLES;
			end else begin
				// reserved and self clearing bits never stored
				state_nxt.ctrl = mgmtReq.wrData & CTRL_WR_MASK; // RULE_24
				state_nxt.mode.autoNegRestart =
					mgmtReq.wrData[BIT_ANEG_RESTART]
					& mgmtReq.wrData[BIT_ANEG_EN]; // RULE_19
			end
		end
		if (mgmtReq.rdEn) begin
			state_nxt.rdValid = 1'b1;
			state_nxt.rdData = isCtrlAddr(mgmtReq.addr) ?
				state_r.ctrl : 16'h0000; // RULE_15
		end

		// power state selection
		if (fixedSetupMode) begin
			state_nxt.pwr = PWR_READY; // RULE_10
		end else if ((pwrCtrl.sleepLevel == SLEEP_DEEP)
			&& state_r.wakeReqN) begin
			state_nxt.pwr = PWR_DOWN; // RULE_13
		end else if (ioBaseWrite || memBaseWrite
			|| ioBaseNonZero || memBaseNonZero) begin
			state_nxt.pwr = PWR_UNPOWERED; // RULE_07 RULE_11
		end else begin
			state_nxt.pwr = PWR_READY; // RULE_09
		end

		// clocks and phy power follow the coming state
		state_nxt.clk.phyUnpowered = (state_nxt.pwr == PWR_UNPOWERED)
			& ~remoteWakeMode; // RULE_12
		state_nxt.clk.phyPowerDown = (state_nxt.pwr == PWR_DOWN)
			| state_nxt.clk.phyUnpowered
			| state_nxt.ctrl[BIT_POWER_DOWN]; // RULE_08 RULE_13 RULE_20
		state_nxt.clk.coreClockEn = (state_nxt.pwr == PWR_READY); // RULE_08
		state_nxt.clk.transmitClockEn = (state_nxt.pwr == PWR_READY);
		state_nxt.clk.receiveClockEn = (state_nxt.pwr == PWR_READY);

		// operating mode
		state_nxt.mode.loopback = state_nxt.ctrl[BIT_LOOPBACK]; // RULE_17
		state_nxt.mode.speed100 = state_nxt.ctrl[BIT_SPEED]; // RULE_18
		state_nxt.mode.fullDuplex = state_nxt.ctrl[BIT_DUPLEX]; // RULE_18
		state_nxt.mode.autoNegEnable = state_nxt.ctrl[BIT_ANEG_EN];
		state_nxt.mode.dataPathEnable = ~state_nxt.ctrl[BIT_ISOLATE]
			& ~state_nxt.ctrl[BIT_POWER_DOWN]; // RULE_20 RULE_21
		state_nxt.mode.resetBusy = state_nxt.ctrl[BIT_RESET];
		// one cycle response is well inside both bit time limits
		state_nxt.mode.collision = state_nxt.mode.dataPathEnable
			& ((state_r.ctrl[BIT_COL_TEST] & txDataActive)
			| (~state_r.ctrl[BIT_LOOPBACK]
			& mediumCollision)); // RULE_17 RULE_22

		// stored wake frames drain once receive is back
		state_nxt.rxDrain = receiveEnabled
			& ~isSleeping(pwrCtrl.sleepLevel)
			& (state_nxt.pwr == PWR_READY); // RULE_06
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			state_r.pwr <= PWR_READY;
			state_r.cause <= '0;
			state_r.pending <= 1'b0;
			state_r.wakeReqN <= 1'b1;
			state_r.ctrl <= CTRL_RESET; // RULE_15
			state_r.rstCnt <= 8'h00;
			state_r.rdData <= 16'h0000;
			state_r.rdValid <= 1'b0;
			state_r.clk <= '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
			state_r.mode <= '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1,
				1'b0, 1'b0};
			state_r.rxDrain <= 1'b0;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign mgmtRdData = state_r.rdData;
	assign mgmtRdValid = state_r.rdValid;
	assign wakeCause = state_r.cause;
	assign wakePending = state_r.pending;
	assign wakeOut = state_r.pending; // RULE_01
	assign wakeRequest_n = state_r.wakeReqN;
	assign sleep_level_field = state_r.pwr;
	assign clkPwr = state_r.clk;
	assign phyMode = state_r.mode;
	assign rxWakeDrain = state_r.rxDrain;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_wake_set;
		@(posedge ref_clk) disable iff (!reset_n)
		(|(wakeEventIn & pwrCtrl.wakeEnable)
			&& isSleeping(pwrCtrl.sleepLevel))
		|=> wakePending && wakeOut;
	endproperty
	a_wake_set: assert property (p_wake_set) // RULE_01
		else $error("wake event did not set pending");

	property p_no_wake_full_power;
		@(posedge ref_clk) disable iff (!reset_n)
		(!isSleeping(pwrCtrl.sleepLevel) && !wakePending)
		|=> !wakePending;
	endproperty
	a_no_wake_full_power: assert property (p_no_wake_full_power) // RULE_23
		else $error("wake pending raised at full power");

	property p_req_release;
		@(posedge ref_clk) disable iff (!reset_n)
		!pwrCtrl.wakeRequestEnable |=> wakeRequest_n;
	endproperty
	a_req_release: assert property (p_req_release) // RULE_02
		else $error("wake request held without enable");

	property p_fixed_ready;
		@(posedge ref_clk) disable iff (!reset_n)
		fixedSetupMode |=> sleep_level_field == PWR_READY;
	endproperty
	a_fixed_ready: assert property (p_fixed_ready) // RULE_10
		else $error("fixed setup left the ready state");

	property p_base_unpowered;
		@(posedge ref_clk) disable iff (!reset_n)
		(ioBaseWrite && !fixedSetupMode
			&& pwrCtrl.sleepLevel != SLEEP_DEEP)
		|=> sleep_level_field == PWR_UNPOWERED
			&& !clkPwr.coreClockEn && !clkPwr.receiveClockEn;
	endproperty
	a_base_unpowered: assert property (p_base_unpowered) // RULE_07 RULE_08
		else $error("base write did not gate clocks");

	property p_remote_wake_phy;
		@(posedge ref_clk) disable iff (!reset_n)
		remoteWakeMode |=> !clkPwr.phyUnpowered;
	endproperty
	a_remote_wake_phy: assert property (p_remote_wake_phy) // RULE_12
		else $error("unpowered reached phy in remote wake");

	property p_deep_down;
		@(posedge ref_clk) disable iff (!reset_n)
		(pwrCtrl.sleepLevel == SLEEP_DEEP && wakeRequest_n
			&& !fixedSetupMode)
		|=> sleep_level_field == PWR_DOWN && clkPwr.phyPowerDown;
	endproperty
	a_deep_down: assert property (p_deep_down) // RULE_13
		else $error("deep sleep did not power down");

	property p_soft_reset;
		@(posedge ref_clk) disable iff (!reset_n)
		(mgmtReq.wrEn && isCtrlAddr(mgmtReq.addr) && !resetBusy
			&& mgmtReq.wrData[BIT_RESET])
		|=> phyMode.resetBusy [*8];
	endproperty
	a_soft_reset: assert property (p_soft_reset) // RULE_16
		else $error("reset bit cleared too early");

	property p_restart_gate;
		@(posedge ref_clk) disable iff (!reset_n)
		(ctrlWrite && !mgmtReq.wrData[BIT_ANEG_EN])
		|=> !phyMode.autoNegRestart;
	endproperty
	a_restart_gate: assert property (p_restart_gate) // RULE_19
		else $error("restart without autoneg enable");

	property p_reserved_zero;
		@(posedge ref_clk) disable iff (!reset_n)
		mgmtRdValid |-> mgmtRdData[6:0] == 7'h00
			&& !mgmtRdData[BIT_ANEG_RESTART];
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) // RULE_24
		else $error("reserved bits read nonzero");

	property p_isolate_col;
		@(posedge ref_clk) disable iff (!reset_n)
		!phyMode.dataPathEnable |-> !phyMode.collision;
	endproperty
	a_isolate_col: assert property (p_isolate_col) // RULE_20 RULE_21
		else $error("collision while data path disabled");

	property p_col_test;
		@(posedge ref_clk) disable iff (!reset_n)
		(state_r.ctrl[BIT_COL_TEST] && txDataActive
			&& !state_nxt.ctrl[BIT_ISOLATE]
			&& !state_nxt.ctrl[BIT_POWER_DOWN])
		|=> phyMode.collision;
	endproperty
	a_col_test: assert property (p_col_test) // RULE_22
		else $error("collision test did not assert");

	property p_state_excl;
		@(posedge ref_clk) disable iff (!reset_n)
		$onehot(sleep_level_field);
	endproperty
	a_state_excl: assert property (p_state_excl) // RULE_07
		else $error("power states not exclusive");

	property p_unpowered_gated;
		@(posedge ref_clk) disable iff (!reset_n)
		sleep_level_field == PWR_UNPOWERED |-> !clkPwr.coreClockEn
			&& !clkPwr.transmitClockEn && !clkPwr.receiveClockEn;
	endproperty
	a_unpowered_gated: assert property (p_unpowered_gated) // RULE_08
		else $error("clocks running while unpowered");

	property p_ready_powered;
		@(posedge ref_clk) disable iff (!reset_n)
		sleep_level_field == PWR_READY |-> !clkPwr.phyUnpowered
			&& clkPwr.coreClockEn && clkPwr.transmitClockEn
			&& clkPwr.receiveClockEn;
	endproperty
	a_ready_powered: assert property (p_ready_powered) // RULE_09
		else $error("ready state without phy power or clocks");

	// only bit 15 may move while the soft reset runs
	property p_busy_write_drop;
		@(posedge ref_clk) disable iff (!reset_n)
		(resetBusy && mgmtReq.wrEn) |=> $stable(state_r.ctrl[14:0]);
	endproperty
	a_busy_write_drop: assert property (p_busy_write_drop) // RULE_16
		else $error("write taken during phy reset");

endmodule : wpc_wake_power_ctrl

`default_nettype wire

// *** include/wpc_pkg.sv ***
// package: constants and types of the wake, power and phy control block
package wpc_pkg;

	// ------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	// phy software reset duration in ns
	localparam int PHY_RESET_NS = 1000;
	localparam int PHY_RESET_CYCLES_I =
		(PHY_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] PHY_RESET_CYCLES = PHY_RESET_CYCLES_I[7:0];

	// ------------------------------------------------------------
	// phy basic control register
	// ------------------------------------------------------------
	localparam logic [4:0] CTRL_ADDR = 5'h00;
	localparam logic [15:0] CTRL_RESET = 16'h3100;
	// bits 6..0 reserved, bit 9 self clearing, bit 15 handled apart
	localparam logic [15:0] CTRL_WR_MASK = 16'h7D80;
	localparam int BIT_RESET = 15;
	localparam int BIT_LOOPBACK = 14;
	localparam int BIT_SPEED = 13;
	localparam int BIT_ANEG_EN = 12;
	localparam int BIT_POWER_DOWN = 11;
	localparam int BIT_ISOLATE = 10;
	localparam int BIT_ANEG_RESTART = 9;
	localparam int BIT_DUPLEX = 8;
	localparam int BIT_COL_TEST = 7;

	// ------------------------------------------------------------
	// sleep level field encodings
	// ------------------------------------------------------------
	localparam logic [1:0] SLEEP_FULL_POWER = 2'h0;
	localparam logic [1:0] SLEEP_DEEP = 2'h3;

	// number of wake causes: frame match, special frame, link change
	localparam int WAKE_CAUSES = 3;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		PWR_READY = 3'h1,
		PWR_UNPOWERED = 3'h2,
		PWR_DOWN = 3'h4
	} wpc_pwr_t;

	typedef struct packed {
		logic wrEn;
		logic rdEn;
		logic [4:0] addr;
		logic [15:0] wrData;
	} wpc_mgmt_req_t;

	typedef struct packed {
		logic [1:0] sleepLevel;
		logic wakeRequestEnable;
		logic wakePendingClear;
		logic [WAKE_CAUSES-1:0] wakeCauseClear;
		logic [WAKE_CAUSES-1:0] wakeEnable;
	} wpc_pwr_ctrl_t;

	typedef struct packed {
		logic phyUnpowered;
		logic phyPowerDown;
		logic coreClockEn;
		logic transmitClockEn;
		logic receiveClockEn;
	} wpc_clk_pwr_t;

	typedef struct packed {
		logic loopback;
		logic speed100;
		logic fullDuplex;
		logic autoNegEnable;
		logic autoNegRestart;
		logic dataPathEnable;
		logic collision;
		logic resetBusy;
	} wpc_phy_mode_t;

endpackage : wpc_pkg

// *** verification/wpc_host_model.sv ***
// host side model: management accesses and power control settings
`timescale 1ns/1ps
`default_nettype none

module wpc_host_model (
	input wire logic ref_clk,
	output var wpc_pkg::wpc_mgmt_req_t mgmtReq,
	output var wpc_pkg::wpc_pwr_ctrl_t pwrCtrl,
	input wire logic [15:0] mgmtRdData,
	input wire logic mgmtRdValid
);
	import wpc_pkg::*;

	initial begin
		mgmtReq = '0;
		pwrCtrl = '0;
	end

	// ------------------------------------------------------------
	// management port, one 16-bit word per access
	// ------------------------------------------------------------
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		mgmtReq.wrEn <= 1'b1;
		mgmtReq.addr <= a;
		mgmtReq.wrData <= d;
		@(posedge ref_clk);
		mgmtReq.wrEn <= 1'b0;
		// released lines carry junk so nothing leans on stale values
		mgmtReq.addr <= ~a;
		mgmtReq.wrData <= ~d;
		#1;
	endtask : wr

	task automatic rd(input logic [4:0] a, output logic [15:0] d,
		output logic ok);
		@(posedge ref_clk);
		mgmtReq.rdEn <= 1'b1;
		mgmtReq.addr <= a;
		@(posedge ref_clk);
		mgmtReq.rdEn <= 1'b0;
		mgmtReq.addr <= ~a;
		#1;
		ok = mgmtRdValid;
		d = mgmtRdData;
	endtask : rd

	// ------------------------------------------------------------
	// power control
	// ------------------------------------------------------------
	task automatic set_pwr(input logic [1:0] lvl, input logic reqEn,
		input logic [2:0] en);
		@(posedge ref_clk);
		pwrCtrl.sleepLevel <= lvl;
		pwrCtrl.wakeRequestEnable <= reqEn;
		pwrCtrl.wakeEnable <= en;
		#1;
	endtask : set_pwr

	// after reading the causes, software acknowledges them
	task automatic clear_wake;
		@(posedge ref_clk);
		pwrCtrl.wakePendingClear <= 1'b1;
		pwrCtrl.wakeCauseClear <= 3'h7;
		@(posedge ref_clk);
		pwrCtrl.wakePendingClear <= 1'b0;
		pwrCtrl.wakeCauseClear <= 3'h0;
		#1;
	endtask : clear_wake

endmodule : wpc_host_model

`default_nettype wire

// *** verification/wake_power_and_phy_control_bench.sv ***
// testbench of the wake, power and phy control block
`timescale 1ns/1ps
`default_nettype none

module wake_power_and_phy_control_bench;
	import wpc_pkg::*;

	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	wpc_mgmt_req_t mgmtReq;
	wpc_pwr_ctrl_t pwrCtrl;
	logic [15:0] mgmtRdData, d, e;
	logic mgmtRdValid, ok, wakePending, wakeOut, wakeRequest_n, rxWakeDrain;
	logic [2:0] wakeEventIn = 3'h0;
	logic [2:0] wakeCause;
	logic ioBaseWrite = 1'b0, memBaseWrite = 1'b0, ioBaseNonZero = 1'b0;
	logic memBaseNonZero = 1'b0, fixedSetupMode = 1'b0, remoteWakeMode = 1'b0;
	logic receiveEnabled = 1'b0, txDataActive = 1'b0, mediumCollision = 1'b0;
	wpc_pwr_t sleep_level_field;
	wpc_clk_pwr_t clkPwr;
	wpc_phy_mode_t phyMode;
	logic [1:0] lvl;
	int err_total = 0, check_count = 0, seed = 32'h4b5872ac, i, c;

	always #5 ref_clk = ~ref_clk;

	wpc_wake_power_ctrl dut (.ref_clk, .reset_n, .mgmtReq, .mgmtRdData,
		.mgmtRdValid, .pwrCtrl, .wakeEventIn, .ioBaseWrite, .memBaseWrite,
		.ioBaseNonZero, .memBaseNonZero, .fixedSetupMode, .remoteWakeMode,
		.receiveEnabled, .txDataActive, .mediumCollision, .wakeCause,
		.wakePending, .wakeOut, .wakeRequest_n, .sleep_level_field, .clkPwr,
		.phyMode, .rxWakeDrain);

	wpc_host_model host (.ref_clk, .mgmtReq, .pwrCtrl, .mgmtRdData,
		.mgmtRdValid);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic close_out;
		$display("mismatches %0d, comparisons %0d", err_total, check_count);
		if (err_total == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : close_out

	task automatic check(input logic [15:0] seen, input logic [15:0] exp,
		input string msg);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: %s seen %h want %h", $time, msg,
				seen, exp);
		end
	endtask : check

	function automatic logic probe(input int s);
		case (s)
			0: return phyMode.collision;
			1: return phyMode.resetBusy;
			2: return sleep_level_field === PWR_UNPOWERED;
			3: return sleep_level_field === PWR_DOWN;
			default: return sleep_level_field === PWR_READY;
		endcase
	endfunction : probe

	// bounded wait; running out ends the run
	task automatic wait_for(input int s, input logic v, input int n);
		int k;
		k = 0;
		while (probe(s) !== v && k < n) begin
			@(posedge ref_clk);
			#1;
			k++;
		end
		check(16'(probe(s)), 16'(v), "wait ran out");
		if (probe(s) !== v) close_out();
	endtask : wait_for

	task automatic pulse_event(input logic [2:0] v);
		@(posedge ref_clk) wakeEventIn <= v;
		@(posedge ref_clk) wakeEventIn <= 3'h0;
		#1;
	endtask : pulse_event

	initial begin
		#500000;
		err_total++;
		$display("unexpected at %0t: run too long", $time);
		close_out();
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (3) @(posedge ref_clk);
		reset_n <= 1'b1;
		host.rd(5'h00, d, ok);
		check(d, 16'h3100, "ctrl reset");
		check(16'(ok), 16'h1, "read valid");
		// corners first, then random words; bit 15 kept apart
		for (i = 0; i < 10; i++) begin
			e = (i == 0) ? 16'h7FFF : (i == 1) ? 16'h0000 :
				16'($random(seed)) & 16'h7FFF;
			host.wr(5'h00, e);
			check(16'(phyMode.autoNegRestart), 16'(e[9] & e[12]), "restart");
			host.rd(5'h00, d, ok);
			check(d, e & 16'h7D80, "ctrl readback");
			check(16'({phyMode.loopback, phyMode.speed100, phyMode.autoNegEnable,
				phyMode.fullDuplex}), 16'({e[14], e[13], e[12], e[8]}), "mode");
			check(16'(phyMode.dataPathEnable), 16'(!(e[11] | e[10])), "path");
			check(16'(clkPwr.phyPowerDown), 16'(e[11]), "power down");
		end
		host.wr(5'h01, 16'hFFFF);
		host.rd(5'h01, d, ok);
		check(d, 16'h0000, "other address");
		host.rd(5'h00, d, ok);
		check(d, e & 16'h7D80, "other address write");
		host.wr(5'h00, 16'h2080);
		@(posedge ref_clk) txDataActive <= 1'b1;
		#1;
		wait_for(0, 1'b1, 512);
		@(posedge ref_clk) txDataActive <= 1'b0;
		#1;
		wait_for(0, 1'b0, 4);
		host.wr(5'h00, 16'h4000);
		@(posedge ref_clk) mediumCollision <= 1'b1;
		repeat (3) @(posedge ref_clk);
		#1;
		check(16'(phyMode.collision), 16'h0, "loopback collision");
		host.wr(5'h00, 16'h0000);
		wait_for(0, 1'b1, 3);
		@(posedge ref_clk) mediumCollision <= 1'b0;
		host.wr(5'h00, 16'h8000);
		host.rd(5'h00, d, ok);
		check(d, 16'hB100, "reset busy");
		host.wr(5'h00, 16'h0000);
		wait_for(1, 1'b0, 200);
		host.rd(5'h00, d, ok);
		check(d, 16'h3100, "write in reset");
		host.set_pwr(SLEEP_FULL_POWER, 1'b1, 3'h7);
		pulse_event(3'h7);
		check(16'({wakeCause, wakePending}), 16'h0, "wake at full");
		lvl = 2'(1 + {$random(seed)} % 3);
		c = {$random(seed)} % 3;
		host.set_pwr(lvl, 1'b1, 3'(1 << c));
		pulse_event(3'h7);
		check(16'({wakeCause, wakePending, wakeOut, wakeRequest_n}),
			16'({3'(1 << c), 3'b110}), "wake");
		host.set_pwr(SLEEP_DEEP, 1'b0, 3'(1 << c));
		repeat (2) @(posedge ref_clk);
		#1;
		check(16'(wakeRequest_n), 16'h1, "request release");
		wait_for(3, 1'b1, 4);
		check(16'(clkPwr[3:0]), 16'h8, "deep sleep clocks");
		host.clear_wake();
		check(16'({wakeCause, wakePending}), 16'h0, "clear");
		// transmit stays idle for the rest of the run
		@(posedge ref_clk) txDataActive <= 1'b0;
		host.set_pwr(SLEEP_FULL_POWER, 1'b0, 3'h0);
		wait_for(4, 1'b1, 4);
		@(posedge ref_clk) ioBaseWrite <= 1'b1;
		@(posedge ref_clk) ioBaseWrite <= 1'b0;
		#1;
		wait_for(2, 1'b1, 3);
		@(posedge ref_clk) begin
			memBaseNonZero <= 1'b1;
			receiveEnabled <= 1'b1;
		end
		#1;
		wait_for(2, 1'b1, 4);
		repeat (2) @(posedge ref_clk);
		#1;
		check(16'(clkPwr), 16'h18, "unpowered");
		check(16'(rxWakeDrain), 16'h0, "no drain while unpowered");
		@(posedge ref_clk) remoteWakeMode <= 1'b1;
		repeat (3) @(posedge ref_clk);
		#1;
		check(16'(clkPwr), 16'h00, "remote wake");
		@(posedge ref_clk) begin
			fixedSetupMode <= 1'b1;
			ioBaseNonZero <= 1'b1;
			receiveEnabled <= 1'b1;
		end
		#1;
		wait_for(4, 1'b1, 4);
		repeat (2) @(posedge ref_clk);
		#1;
		check(16'(clkPwr), 16'h07, "ready clocks");
		check(16'(rxWakeDrain), 16'h1, "drain");
		close_out();
	end

endmodule : wake_power_and_phy_control_bench

`default_nettype wire
